// ---- logic/spmc_map.svh ----
// Purpose: register map and timing constants of the switch power mode control
// Assumes: AHB-Lite word registers, byte address = index * 4
// Notes: indices compare against haddr[7:2]
`ifndef SPMC_MAP_SVH
`define SPMC_MAP_SVH
// ==========================================
// Register indices
`define SPMC_MODE_IDX 6'd14
`define SPMC_SLEEP_IDX 6'd15
`define SPMC_PORTPD_IDX 6'd16
`define SPMC_STAT_IDX 6'd17
// ==========================================
// Field positions
`define SPMC_MODE_LSB 3
`define SPMC_MODE_MSB 4
`define SPMC_SLEEP_MSB 7
`define SPMC_STAT_PSAVE 6
`define SPMC_STAT_ENERGY 7
// ==========================================
// Reset values
`define SPMC_MODE_RST 2'b00
`define SPMC_SLEEP_RST 8'h50
// ==========================================
// Timing
`define SPMC_CLK_MHZ 200
`define SPMC_PULSE_NS 120
`define SPMC_PULSE_PERIOD_MS 1000
`define SPMC_TICK_US 1000
`endif

// ---- logic/spmc_pkg.sv ----
// Purpose: types of the switch power mode control
// Assumes: constants live in spmc_map.svh
// Notes: state codes are one-hot
package spmc_pkg;
    // ==========================================
    // Power mode field encoding
    typedef enum logic [1:0] {
        SPMC_NORMAL = 2'b00,
        SPMC_ENERGY = 2'b01,
        SPMC_SOFTPD = 2'b10,
        SPMC_PSAVE = 2'b11
    } spmc_mode_t;
    // ==========================================
    // Controller states
    typedef enum logic [5:0] {
        ST_NORMAL = 6'b000001,
        ST_PSAVE = 6'b000010,
        ST_ED_ACT = 6'b000100,
        ST_ED_LOW = 6'b001000,
        ST_SOFTPD = 6'b010000,
        ST_WAKE = 6'b100000
    } spmc_state_t;
    // ==========================================
    // Global enables, link pulse and internal reset
    typedef struct packed {
        logic pllClkEn;
        logic macEn;
        logic hostIfEn;
        logic edMonitorEn;
        logic linkPulse;
        logic internalReset;
    } spmc_pwr_t;
endpackage

// ---- logic/spmc_power_ctrl.sv ----
// Purpose: power mode sequencer of a four-port switch, AHB-Lite register slave
// Assumes: single clock, synchronous active-high reset, inputs synchronous
// Notes: the slave answers in every mode so a host access can wake it from soft power-down
// Operation
// - Mode field 00 normal, 01 energy detect, 10 soft power-down, 11 power saving.
// - Per-port power-down bit set powers that PHY port down regardless of mode.
// - PHY management control bit 11 also powers that port down.
// - Mode field resets to 00, so operation starts normal.
// - Normal mode: clocks run, PHYs and MACs on, host interface serves accesses.
// - From normal, move to whatever other mode the host writes.
// - Energy-detect low state sends 120 ns link pulses once per second.
// - Enter low state after no energy longer than the go-sleep time.
// - Low state keeps monitoring and returns to normal state on energy.
// - Low state disables everything but receiver energy detect.
// - Energy-detect normal state transmits and receives packets as usual.
// - Soft power-down stops clocks and switches off all PHYs and MACs.
// - Host access in soft power-down wakes to normal with internal reset.
// - Power saving acts only with autoneg on, cable out, mode 11.
// - Power saving keeps clocks, MAC, registers and host interface alive.
// - Power saving keeps transmitter on, switches off unused receiver only.
// - Power saving restores full PHY power when link activity resumes.
// - From power saving, move to whatever other mode the host writes.
`timescale 1ns/100ps
`default_nettype none
`include "spmc_map.svh"
module spmc_power_ctrl #(
    parameter int NPHY = 2,
    parameter int TICK_CYCLES = `SPMC_TICK_US * `SPMC_CLK_MHZ,
    parameter int PERIOD_CYCLES = `SPMC_PULSE_PERIOD_MS * 1000 * `SPMC_CLK_MHZ
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NPHY-1:0] energyDetect,
    input wire logic [NPHY-1:0] miimPowerDown,
    input wire logic autoNegEn,
    input wire logic cableConnected,
    output spmc_pkg::spmc_pwr_t pwr,
    output logic [NPHY-1:0] phyPowerDown,
    output logic [NPHY-1:0] phyTxEn,
    output logic [NPHY-1:0] phyRxEn
);
    import spmc_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES);
    localparam int PW = $clog2(PERIOD_CYCLES);
    localparam int PULSE_CYCLES = (`SPMC_PULSE_NS * `SPMC_CLK_MHZ) / 1000;

    typedef struct packed {
        spmc_state_t st;
        spmc_mode_t mode;
        logic [7:0] goSleep;
        logic [NPHY-1:0] portPd;
        logic [TW-1:0] tick;
        logic [8:0] idle;
        logic [PW-1:0] pulse;
        logic pulseOn;
        logic dpValid;
        logic dpWrite;
        logic [5:0] dpIdx;
        logic [31:0] rdata;
    } spmc_core_t;

    localparam spmc_core_t RST = '{
        st: ST_NORMAL,
        mode: spmc_mode_t'(`SPMC_MODE_RST),
        goSleep: `SPMC_SLEEP_RST,
        portPd: '0,
        tick: '0,
        idle: 9'h000,
        pulse: '0,
        pulseOn: 1'b0,
        dpValid: 1'b0,
        dpWrite: 1'b0,
        dpIdx: 6'h00,
        rdata: 32'h0000_0000
    };

    spmc_core_t q;
    spmc_core_t d;
    logic addrPhase;
    logic hostOn;
    logic anyEnergy;
    logic psaveOn;
    logic tickHit;
    logic [31:0] rd;

    // ==========================================
    // Mode to state
    function automatic spmc_state_t modeState(input spmc_mode_t m);
        spmc_state_t s;
        s = ST_NORMAL;
        case (m)
            SPMC_NORMAL: s = ST_NORMAL;
            SPMC_ENERGY: s = ST_ED_ACT;
            SPMC_SOFTPD: s = ST_SOFTPD;
            SPMC_PSAVE: s = ST_PSAVE;
            default: s = ST_NORMAL;
        endcase
        return s;
    endfunction

    assign anyEnergy = |energyDetect;
    assign addrPhase = hsel & htrans[1] & hready;
    // Register access off in low states and wake; an access wakes soft power-down only
    assign hostOn = (q.st != ST_ED_LOW) && (q.st != ST_SOFTPD) && (q.st != ST_WAKE);
    assign psaveOn = (q.st == ST_PSAVE) && autoNegEn && !cableConnected && !anyEnergy;
    assign tickHit = (q.tick == TW'(TICK_CYCLES - 1));

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        rd = 32'h0000_0000;
        d.dpValid = addrPhase;
        d.dpWrite = hwrite;
        d.dpIdx = haddr[7:2];
        if (q.dpValid && q.dpWrite && hostOn) begin
            case (q.dpIdx)
                `SPMC_MODE_IDX: begin
                    d.mode = spmc_mode_t'(hwdata[`SPMC_MODE_MSB:`SPMC_MODE_LSB]);
                end
                `SPMC_SLEEP_IDX: begin
                    d.goSleep = hwdata[`SPMC_SLEEP_MSB:0];
                end
                `SPMC_PORTPD_IDX: begin
                    d.portPd = hwdata[NPHY-1:0];
                end
                default: begin
                end
            endcase
        end
        d.tick = tickHit ? '0 : q.tick + TW'(1);
        if (anyEnergy || (q.st != ST_ED_ACT)) begin
            d.idle = 9'h000;
        end else if (tickHit && (q.idle != 9'h1ff)) begin
            d.idle = q.idle + 9'h001;
        end
        if (q.st != ST_ED_LOW) begin
            d.pulse = '0;
        end else begin
            d.pulse = (q.pulse == PW'(PERIOD_CYCLES - 1)) ? '0 : q.pulse + PW'(1);
        end
        // Read data sees a write finishing in the same cycle
        if (addrPhase && !hwrite && hostOn) begin
            case (haddr[7:2])
                `SPMC_MODE_IDX: begin
                    rd[`SPMC_MODE_MSB:`SPMC_MODE_LSB] = d.mode;
                end
                `SPMC_SLEEP_IDX: begin
                    rd[`SPMC_SLEEP_MSB:0] = d.goSleep;
                end
                `SPMC_PORTPD_IDX: begin
                    rd[NPHY-1:0] = d.portPd;
                end
                `SPMC_STAT_IDX: begin
                    rd[5:0] = q.st;
                    rd[`SPMC_STAT_PSAVE] = psaveOn;
                    rd[`SPMC_STAT_ENERGY] = anyEnergy;
                end
                default: begin
                end
            endcase
        end
        d.rdata = rd;
        case (q.st)
            ST_NORMAL: begin
                d.st = modeState(q.mode);
            end
            ST_PSAVE: begin
                d.st = modeState(q.mode);
            end
            ST_ED_ACT: begin
                if (q.mode != SPMC_ENERGY) begin
                    d.st = modeState(q.mode);
                end else if (!anyEnergy && (q.idle > {1'b0, q.goSleep})) begin
                    d.st = ST_ED_LOW;
                end
            end
            ST_ED_LOW: begin
                if (anyEnergy) begin
                    d.st = ST_ED_ACT;
                end
            end
            ST_SOFTPD: begin
                if (addrPhase) begin
                    d = RST;
                    d.st = ST_WAKE;
                end
            end
            ST_WAKE: begin
                d.st = ST_NORMAL;
            end
            default: begin
                d.st = ST_NORMAL;
            end
        endcase
        // First pulse starts with the low state, none lingers after it
        d.pulseOn = (d.st == ST_ED_LOW) && (d.pulse < PW'(PULSE_CYCLES));
    end

    // ==========================================
    // State register
    always_ff @(posedge clock) begin
        if (reset) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    always_comb begin
        pwr.pllClkEn = hostOn || (q.st == ST_WAKE);
        pwr.macEn = hostOn;
        pwr.hostIfEn = hostOn;
        pwr.edMonitorEn = (q.st == ST_ED_LOW);
        pwr.linkPulse = q.pulseOn;
        pwr.internalReset = (q.st == ST_WAKE);
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPHY; gi++) begin : g_phy
            assign phyPowerDown[gi] = q.portPd[gi] | miimPowerDown[gi];
            assign phyTxEn[gi] = !phyPowerDown[gi] && hostOn;
            assign phyRxEn[gi] = !phyPowerDown[gi] && hostOn && !psaveOn;
        end
    endgenerate

    // ==========================================
    // Checks
    logic [7:0] hiCnt;
    always_ff @(posedge clock) begin
        if (reset) begin
            hiCnt <= 8'h00;
        end else begin
            hiCnt <= pwr.linkPulse ? hiCnt + 8'h01 : 8'h00;
        end
    end


    // ==========================================
    // Pulse period helper
    // A rise is a high pulse with no count behind it
    logic [PW-1:0] perCnt;
    logic perSeen;
    always_ff @(posedge clock) begin
        if (reset || (q.st != ST_ED_LOW)) begin
            perCnt <= '0;
            perSeen <= 1'b0;
        end else if (pwr.linkPulse && (hiCnt == 8'h00)) begin
            perCnt <= '0;
            perSeen <= 1'b1;
        end else begin
            perCnt <= perCnt + PW'(1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    chk_mode_reset: assert property ($past(reset) |-> q.mode == SPMC_NORMAL && q.st == ST_NORMAL)
        else $error("mode not normal after reset");
    chk_mode_write_softpd: assert property (q.st == ST_NORMAL && q.dpValid && q.dpWrite &&
        q.dpIdx == `SPMC_MODE_IDX && hwdata[4:3] == 2'b10 |=> ##1 q.st == ST_SOFTPD)
        else $error("soft power-down not entered after write");
    chk_psave_leave: assert property (q.st == ST_PSAVE && q.mode == SPMC_ENERGY |=> q.st == ST_ED_ACT)
        else $error("saving mode did not follow write");
    chk_port_down: assert property (miimPowerDown[0] || q.portPd[0] |-> !phyTxEn[0] && !phyRxEn[0])
        else $error("powered-down port still enabled");
    chk_pulse_width: assert property ($fell(pwr.linkPulse) && q.st == ST_ED_LOW |-> hiCnt == 8'd24)
        else $error("link pulse width wrong");
    chk_go_sleep: assert property (q.st == ST_ED_ACT && q.mode == SPMC_ENERGY && !anyEnergy &&
        q.idle > {1'b0, q.goSleep} |=> q.st == ST_ED_LOW)
        else $error("low state not entered after idle time");
    chk_energy_wake: assert property (q.st == ST_ED_LOW && anyEnergy |=> q.st == ST_ED_ACT
        ##1 pwr.pllClkEn && pwr.macEn)
        else $error("no wake on energy");
    chk_low_off: assert property (q.st == ST_ED_LOW |-> !pwr.pllClkEn && !pwr.macEn &&
        !pwr.hostIfEn && pwr.edMonitorEn && phyTxEn == '0)
        else $error("low state leaves logic powered");
    chk_softpd_off: assert property (q.st == ST_SOFTPD |-> !pwr.pllClkEn && phyRxEn == '0 && !pwr.linkPulse)
        else $error("soft power-down leaves logic powered");
    chk_softpd_wake: assert property (q.st == ST_SOFTPD && addrPhase |=> pwr.internalReset
        ##1 q.st == ST_NORMAL && q.mode == SPMC_NORMAL && q.goSleep == `SPMC_SLEEP_RST)
        else $error("no wake with internal reset");
    chk_rx_gate: assert property (!phyRxEn[0] && phyTxEn[0] |-> q.st == ST_PSAVE && autoNegEn &&
        !cableConnected && !anyEnergy)
        else $error("receiver off outside power saving");
    chk_psave_alive: assert property (q.st == ST_PSAVE |-> pwr.pllClkEn && pwr.macEn && pwr.hostIfEn)
        else $error("power saving stopped clocks");
    chk_idle_restart: assert property (q.st == ST_ED_ACT && anyEnergy |=> q.idle == 9'h000)
        else $error("idle count not restarted");
    chk_idle_count: assert property (q.st == ST_ED_ACT && !anyEnergy && tickHit && q.idle != 9'h1ff
        |=> q.idle == $past(q.idle) + 9'h001)
        else $error("idle count not advanced on tick");
    chk_tick_wrap: assert property (tickHit |=> q.tick == '0)
        else $error("slow tick did not wrap");

    // ==========================================
    // Mode and power checks
    chk_normal_on: assert property (q.st == ST_NORMAL |-> pwr.pllClkEn && pwr.macEn && pwr.hostIfEn &&
        !pwr.edMonitorEn && !hresp)
        else $error("normal mode not fully powered");
    chk_decode_energy: assert property (q.st == ST_NORMAL && q.mode == SPMC_ENERGY |=> q.st == ST_ED_ACT)
        else $error("energy detect code not decoded");
    chk_decode_psave: assert property (q.st == ST_NORMAL && q.mode == SPMC_PSAVE |=> q.st == ST_PSAVE)
        else $error("power saving code not decoded");
    chk_miim_down: assert property (miimPowerDown[NPHY-1] |-> phyPowerDown[NPHY-1] &&
        !phyTxEn[NPHY-1] && !phyRxEn[NPHY-1])
        else $error("management power-down ignored");
    chk_ed_traffic: assert property (q.st == ST_ED_ACT |-> pwr.macEn && phyTxEn == ~phyPowerDown &&
        phyRxEn == ~phyPowerDown)
        else $error("energy detect normal state blocks traffic");
    chk_psave_tx: assert property (q.st == ST_PSAVE |-> phyTxEn == ~phyPowerDown)
        else $error("transmitter off in power saving");
    chk_psave_restore: assert property (q.st == ST_PSAVE && (cableConnected || anyEnergy) |->
        phyRxEn == ~phyPowerDown)
        else $error("receiver not restored on link activity");
    chk_pulse_period: assert property (pwr.linkPulse && hiCnt == 8'h00 && perSeen |->
        perCnt == PW'(PERIOD_CYCLES - 1))
        else $error("link pulse period wrong");
    chk_low_quiet: assert property (q.st != ST_ED_LOW |-> !pwr.linkPulse && !pwr.edMonitorEn)
        else $error("low state outputs outside low state");
    chk_low_hold: assert property (q.st == ST_ED_LOW && !anyEnergy |=> q.st == ST_ED_LOW)
        else $error("low state left without energy");
    chk_softpd_hold: assert property (q.st == ST_SOFTPD && !addrPhase |=> q.st == ST_SOFTPD)
        else $error("soft power-down left without access");
    chk_reset_single: assert property (pwr.internalReset |=> !pwr.internalReset)
        else $error("internal reset longer than one cycle");
    chk_wake_normal: assert property (q.st == ST_WAKE |=> q.st == ST_NORMAL)
        else $error("wake did not return to normal");
    chk_psave_regs: assert property (q.st == ST_PSAVE && !q.dpValid |=> q.goSleep == $past(q.goSleep) &&
        q.portPd == $past(q.portPd))
        else $error("registers changed in power saving");
    chk_sleep_reset: assert property ($past(reset) |-> q.goSleep == `SPMC_SLEEP_RST && q.portPd == '0)
        else $error("registers not default after reset");

    cov_ed_sleep_wake: cover property (q.st == ST_ED_LOW ##[1:1000] q.st == ST_ED_ACT);
    cov_softpd_wake: cover property (q.st == ST_SOFTPD ##1 pwr.internalReset);
    cov_psave_rx_off: cover property (psaveOn ##1 !psaveOn);
    cov_pulse_period: cover property (pwr.linkPulse && hiCnt == 8'h00 && perSeen);
    cov_port_down: cover property (phyPowerDown == '1);
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: self-checking bench of the switch power mode control
// Assumes: short tick and pulse period so energy detect runs quickly
// Notes: bus task waits on hreadyout; a watchdog ends any hang
`timescale 1ns/100ps
`default_nettype none
`include "spmc_map.svh"
module tb;
    import spmc_pkg::*;
    // ==========================================
    // Setup
    localparam int TICK = 4;
    localparam int PER = 64;
    localparam logic [31:0] AMODE = 32'({`SPMC_MODE_IDX, 2'b00});
    localparam logic [31:0] ASLEEP = 32'({`SPMC_SLEEP_IDX, 2'b00});
    localparam logic [31:0] APD = 32'({`SPMC_PORTPD_IDX, 2'b00});
    localparam logic [31:0] ASTAT = 32'({`SPMC_STAT_IDX, 2'b00});
    typedef struct packed {
        logic [1:0] mode;
        logic [5:0] st;
        logic [3:0] en;
        logic [1:0] rx;
    } spmc_row_t;
    spmc_row_t rows [3] = '{'{2'b00, 6'h01, 4'he, 2'b11}, '{2'b11, 6'h02, 4'he, 2'b11},
        '{2'b01, 6'h04, 4'he, 2'b11}};
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [1:0] energyDetect = 2'b11;
    logic [1:0] miimPowerDown = 2'b00;
    logic autoNegEn = 1'b1;
    logic cableConnected = 1'b0;
    spmc_pwr_t pwr;
    logic [1:0] phyPowerDown;
    logic [1:0] phyTxEn;
    logic [1:0] phyRxEn;
    int err_count = 0;
    int n_tests = 0;
    int irCount = 0;
    always #2.5 clock = ~clock;
    always @(negedge clock) if (pwr.internalReset === 1'b1) irCount <= irCount + 1;
    spmc_power_ctrl #(.NPHY(2), .TICK_CYCLES(TICK), .PERIOD_CYCLES(PER)) dut_u (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .energyDetect(energyDetect),
        .miimPowerDown(miimPowerDown), .autoNegEn(autoNegEn), .cableConnected(cableConnected),
        .pwr(pwr), .phyPowerDown(phyPowerDown), .phyTxEn(phyTxEn), .phyRxEn(phyRxEn));
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read data taken at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Run needs a few hundred cycles; generous margin
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        end_sim();
    end
    // ==========================================
    // Sequence
    initial begin
        logic [31:0] v;
        int k;
        int n;
        int ir;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        settle(1);
        chk(32'({pwr.pllClkEn, pwr.macEn, pwr.hostIfEn, pwr.edMonitorEn}), 32'he);
        rdc(AMODE, 32'h0);
        chk(32'(hresp), 32'h0);
        rdc(ASLEEP, 32'(`SPMC_SLEEP_RST));
        rdc(APD, 32'h0);
        rdc(32'h80, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(AMODE, 32'({rows[i].mode, 3'b000}));
            settle(2);
            chk(32'({pwr.pllClkEn, pwr.macEn, pwr.hostIfEn, pwr.edMonitorEn}), 32'(rows[i].en));
            chk(32'(phyRxEn), 32'(rows[i].rx));
            bus(1'b0, ASTAT, 32'h0, v);
            chk(32'(v[5:0]), 32'(rows[i].st));
            wr(AMODE, 32'h0);
        end
        wr(APD, 32'h1);
        settle(1);
        chk(32'(phyPowerDown), 32'h1);
        chk(32'(phyTxEn), 32'h2);
        @(posedge clock) miimPowerDown <= 2'b10;
        settle(0);
        chk(32'(phyPowerDown), 32'h3);
        @(posedge clock) miimPowerDown <= 2'b00;
        wr(APD, 32'h0);
        wr(AMODE, 32'h18);
        @(posedge clock) energyDetect <= 2'b00;
        settle(2);
        chk(32'(phyRxEn), 32'h0);
        chk(32'({phyTxEn, pwr.pllClkEn, pwr.macEn, pwr.hostIfEn}), 32'h1f);
        bus(1'b0, ASTAT, 32'h0, v);
        chk(32'(v[6]), 32'h1);
        @(posedge clock) cableConnected <= 1'b1;
        settle(0);
        chk(32'(phyRxEn), 32'h3);
        @(posedge clock) cableConnected <= 1'b0;
        autoNegEn <= 1'b0;
        settle(0);
        chk(32'(phyRxEn), 32'h3);
        @(posedge clock) autoNegEn <= 1'b1;
        wr(ASLEEP, 32'h2);
        wr(AMODE, 32'h08);
        bus(1'b0, ASTAT, 32'h0, v);
        chk(32'(v[5:0]), 32'h04);
        @(posedge clock) energyDetect <= 2'b01;
        @(posedge clock) energyDetect <= 2'b00;
        k = 0;
        @(negedge clock);
        while (pwr.edMonitorEn !== 1'b1 && k < 40) begin
            k++;
            @(negedge clock);
        end
        chk(32'(k >= 2 * TICK), 32'h1);
        chk(32'(k <= 3 * TICK + 4), 32'h1);
        chk(32'({pwr.pllClkEn, pwr.macEn, pwr.hostIfEn}), 32'h0);
        n = 0;
        for (int i = 0; i < PER; i++) begin
            if (pwr.linkPulse === 1'b1) n++;
            @(negedge clock);
        end
        chk(32'(n), 32'(`SPMC_PULSE_NS / 5));
        chk(32'(pwr.linkPulse), 32'h1);
        @(posedge clock) energyDetect <= 2'b10;
        settle(1);
        chk(32'({pwr.pllClkEn, pwr.macEn, pwr.hostIfEn, pwr.edMonitorEn}), 32'he);
        bus(1'b0, ASTAT, 32'h0, v);
        chk(32'({v[5:0], phyTxEn, phyRxEn}), 32'h4f);
        wr(APD, 32'h1);
        wr(AMODE, 32'h10);
        settle(1);
        chk(32'({pwr.pllClkEn, pwr.macEn, phyTxEn, phyRxEn}), 32'h0);
        ir = irCount;
        rdc(ASTAT, 32'h0);
        settle(1);
        chk(32'(irCount - ir), 32'h1);
        chk(32'({pwr.pllClkEn, pwr.macEn, pwr.hostIfEn}), 32'h7);
        rdc(AMODE, 32'h0);
        rdc(ASLEEP, 32'(`SPMC_SLEEP_RST));
        rdc(APD, 32'h0);
        wr(APD, 32'h3);
        wr(AMODE, 32'h10);
        settle(1);
        chk(32'({pwr.pllClkEn, pwr.hostIfEn}), 32'h0);
        @(posedge clock) reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        settle(1);
        chk(32'({pwr.pllClkEn, pwr.macEn, pwr.hostIfEn, pwr.edMonitorEn}), 32'he);
        chk(32'(phyPowerDown), 32'h0);
        rdc(AMODE, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
